// >>> design/aspc_consts.svh
// Constants of the asynchronous serial port: register map, fields, reset values
// Behaviour
// - With ring oscillator selected, base count clock is divided from that oscillator.
// - Baud clock is the 5-bit division counter output halved.
// - Unread buffer at next character completion flags overrun; error status stays set until the error register is read.
// - Receiver checks only the first stop bit; second stop bit ignored.
// - On overrun the new character is discarded, buffer keeps old one.
// - Enabling reception with receive pin low starts a reception.
`ifndef ASPC_CONSTS_SVH
`define ASPC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ASPC_OFS_MODE 8'h00
`define ASPC_OFS_BAUD 8'h04
`define ASPC_OFS_TXS 8'h08
`define ASPC_OFS_RXB 8'h0C
`define ASPC_OFS_ERR 8'h10
`define ASPC_OFS_STAT 8'h14

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define ASPC_BIT_POWER 7
`define ASPC_BIT_TXE 6
`define ASPC_BIT_RXE 5
`define ASPC_DIV_LSB 0
`define ASPC_DIV_W 5
`define ASPC_PRE_LSB 5
`define ASPC_PRE_W 3
`define ASPC_BIT_OVR 0
`define ASPC_BIT_FRM 1
`define ASPC_BIT_TXBUSY 0
`define ASPC_BIT_RXFULL 1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define ASPC_RST_MODE 8'h00
`define ASPC_RST_BAUD 8'h1F
`define ASPC_DATA_BITS 4'h8
`define ASPC_RX_LAST_HALF 5'h12
`define ASPC_AXI_OKAY 2'h0
`define ASPC_AXI_DECERR 2'h3

`endif

// >>> design/aspc_pkg.sv
// Types of the asynchronous serial port
package aspc_pkg;

  typedef enum logic [1:0] {
    ASPC_IDLE = 2'h0,
    ASPC_START = 2'h1,
    ASPC_DATA = 2'h3,
    ASPC_STOP = 2'h2
  } aspc_state_t;

  typedef struct packed {
    logic power;
    logic txe;
    logic rxe;
    logic [4:0] spare;
  } aspc_mode_t;

  typedef struct packed {
    logic [2:0] prescale;
    logic [4:0] divisor;
  } aspc_baud_t;

endpackage : aspc_pkg

// >>> design/aspc_baud_gen.sv
// Baud generator: 5-bit division counter and halving stage
`timescale 1ns/100ps
`include "aspc_consts.svh"
module aspc_baud_gen (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_base_tick,
  input wire logic i_run,
  input wire logic [4:0] i_divisor,
  output logic o_half_tick,
  output logic o_bit_tick
);

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic half_r;
  logic half_nxt;
  logic wrap;
  logic [4:0] last;

  // Division counter restarts whenever i_run is low, so each frame starts in phase
  always_comb begin
    last = (i_divisor == 5'h00) ? 5'h00 : i_divisor - 5'h01;
    wrap = i_run && i_base_tick && (cnt_r == last);
    cnt_nxt = cnt_r;
    half_nxt = half_r;
    if (!i_run) begin
      cnt_nxt = 5'h00;
      half_nxt = 1'b0;
    end else if (i_base_tick) begin
      cnt_nxt = wrap ? 5'h00 : cnt_r + 5'h01;
      half_nxt = wrap ? ~half_r : half_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= 5'h00;
      half_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      half_r <= half_nxt;
    end
  end

  assign o_half_tick = wrap;
  assign o_bit_tick = wrap && half_r;

endmodule : aspc_baud_gen

// >>> design/aspc_serial_port.sv
// Asynchronous serial port with AXI4-Lite register access
`timescale 1ns/100ps
`include "aspc_consts.svh"
module aspc_serial_port (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_internal_ring_oscillator_sel,
  input wire logic i_internal_ring_oscillator_clk,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_tx_done,
  output logic o_rx_done,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);

  // ----------------------------------------------------------------
  // Pin synchronisers and base clock
  // ----------------------------------------------------------------
  logic [1:0] rxd_s_r;
  logic [2:0] ring_s_r;
  logic [7:0] pre_r;
  logic [7:0] pre_nxt;
  logic src_tick;
  logic base_tick;
  logic rxd;
  aspc_pkg::aspc_mode_t mode_r, mode_nxt;
  aspc_pkg::aspc_baud_t baud_r, baud_nxt;
  logic [7:0] pre_mask;

  assign rxd = rxd_s_r[1];
  // Ring oscillator edges drive the prescaler instead of the core clock
  assign src_tick = i_internal_ring_oscillator_sel ? (ring_s_r[1] && !ring_s_r[2]) : 1'b1;
  assign pre_mask = (8'h01 << baud_r.prescale) - 8'h01;
  assign base_tick = src_tick && ((pre_r & pre_mask) == pre_mask);
  assign pre_nxt = src_tick ? pre_r + 8'h01 : pre_r;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rxd_s_r <= 2'h3;
      ring_s_r <= 3'h0;
      pre_r <= 8'h00;
    end else begin
      rxd_s_r <= {rxd_s_r[0], i_rxd};
      ring_s_r <= {ring_s_r[1:0], i_internal_ring_oscillator_clk};
      pre_r <= pre_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Enables, resynchronised on the base clock
  // ----------------------------------------------------------------
  logic tx_en_r, rx_en_r, tx_en_nxt, rx_en_nxt;

  always_comb begin
    tx_en_nxt = tx_en_r;
    rx_en_nxt = rx_en_r;
    if (!mode_r.power) begin
      tx_en_nxt = 1'b0;
      rx_en_nxt = 1'b0;
    end else if (base_tick) begin
      tx_en_nxt = mode_r.txe;
      rx_en_nxt = mode_r.rxe;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  aspc_pkg::aspc_state_t tx_st_r, tx_st_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_cnt_r, tx_cnt_nxt;
  logic txd_r, txd_nxt;
  logic tx_pend_r, tx_pend_nxt;
  logic tx_done_nxt, tx_done_r;
  logic tx_bit;
  logic txs_wr;
  logic [7:0] txs_data;

  aspc_baud_gen u_tx_baud (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_base_tick(base_tick),
    .i_run(tx_en_r && (tx_st_r != aspc_pkg::ASPC_IDLE)),
    .i_divisor(baud_r.divisor),
    .o_half_tick(),
    .o_bit_tick(tx_bit)
  );

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    txd_nxt = txd_r;
    tx_pend_nxt = tx_pend_r;
    tx_done_nxt = 1'b0;
    if (!tx_en_r) begin
      tx_st_nxt = aspc_pkg::ASPC_IDLE;
      tx_pend_nxt = 1'b0;
      txd_nxt = 1'b1;
    end else begin
      if (txs_wr) begin
        tx_sh_nxt = txs_data;
        tx_pend_nxt = 1'b1;
      end
      unique case (tx_st_r)
        aspc_pkg::ASPC_IDLE: begin
          if (tx_pend_r) begin
            tx_st_nxt = aspc_pkg::ASPC_START;
            tx_pend_nxt = txs_wr;
            txd_nxt = 1'b0;
          end
        end
        aspc_pkg::ASPC_START: begin
          if (tx_bit) begin
            tx_st_nxt = aspc_pkg::ASPC_DATA;
            txd_nxt = tx_sh_r[0];
            tx_cnt_nxt = 4'h1;
          end
        end
        aspc_pkg::ASPC_DATA: begin
          if (tx_bit) begin
            if (tx_cnt_r == `ASPC_DATA_BITS) begin
              tx_st_nxt = aspc_pkg::ASPC_STOP;
              txd_nxt = 1'b1;
            end else begin
              txd_nxt = tx_sh_r[tx_cnt_r[2:0]];
              tx_cnt_nxt = tx_cnt_r + 4'h1;
            end
          end
        end
        aspc_pkg::ASPC_STOP: begin
          if (tx_bit) begin
            tx_st_nxt = aspc_pkg::ASPC_IDLE;
            tx_done_nxt = 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  aspc_pkg::aspc_state_t rx_st_r, rx_st_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [7:0] rxb_r, rxb_nxt;
  logic [4:0] rx_half_r, rx_half_nxt;
  logic rx_full_r, rx_full_nxt;
  logic ovr_r, ovr_nxt, frm_r, frm_nxt;
  logic rx_done_nxt, rx_done_r;
  logic rx_half;
  logic rxb_rd, err_rd;

  aspc_baud_gen u_rx_baud (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_base_tick(base_tick),
    .i_run(rx_en_r && (rx_st_r != aspc_pkg::ASPC_IDLE)),
    .i_divisor(baud_r.divisor),
    .o_half_tick(rx_half),
    .o_bit_tick()
  );

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_sh_nxt = rx_sh_r;
    rxb_nxt = rxb_r;
    rx_half_nxt = rx_half_r;
    rx_done_nxt = 1'b0;
    rx_full_nxt = rxb_rd ? 1'b0 : rx_full_r;
    ovr_nxt = err_rd ? 1'b0 : ovr_r;
    frm_nxt = err_rd ? 1'b0 : frm_r;
    if (!rx_en_r) begin
      rx_st_nxt = aspc_pkg::ASPC_IDLE;
    end else begin
      unique case (rx_st_r)
        aspc_pkg::ASPC_IDLE: begin
          if (!rxd) begin
            rx_st_nxt = aspc_pkg::ASPC_START;
            rx_half_nxt = 5'h00;
          end
        end
        aspc_pkg::ASPC_START: begin
          if (rx_half) begin
            rx_half_nxt = rx_half_r + 5'h01;
            rx_st_nxt = rxd ? aspc_pkg::ASPC_IDLE : aspc_pkg::ASPC_DATA;
          end
        end
        aspc_pkg::ASPC_DATA: begin
          if (rx_half) begin
            rx_half_nxt = rx_half_r + 5'h01;
            if (!rx_half_r[0]) begin
              rx_sh_nxt = {rxd, rx_sh_r[7:1]};
            end
            if (rx_half_r == `ASPC_RX_LAST_HALF - 5'h01) begin
              rx_st_nxt = aspc_pkg::ASPC_STOP;
            end
          end
        end
        aspc_pkg::ASPC_STOP: begin
          if (rx_half) begin
            rx_half_nxt = rx_half_r + 5'h01;
            if (rx_half_r == `ASPC_RX_LAST_HALF) begin
              // Only the middle of the first stop bit is sampled; a second one looks like idle
              rx_st_nxt = aspc_pkg::ASPC_IDLE;
              rx_done_nxt = 1'b1;
              if (!rxd) begin
                frm_nxt = 1'b1;
              end
              if (rx_full_r && !rxb_rd) begin
                ovr_nxt = 1'b1;
              end else begin
                rxb_nxt = rx_sh_r;
                rx_full_nxt = 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_en_r <= 1'b0;
      rx_en_r <= 1'b0;
      tx_st_r <= aspc_pkg::ASPC_IDLE;
      tx_sh_r <= 8'h00;
      tx_cnt_r <= 4'h0;
      txd_r <= 1'b1;
      tx_pend_r <= 1'b0;
      tx_done_r <= 1'b0;
      rx_st_r <= aspc_pkg::ASPC_IDLE;
      rx_sh_r <= 8'h00;
      rxb_r <= 8'h00;
      rx_half_r <= 5'h00;
      rx_full_r <= 1'b0;
      ovr_r <= 1'b0;
      frm_r <= 1'b0;
      rx_done_r <= 1'b0;
    end else begin
      tx_en_r <= tx_en_nxt;
      rx_en_r <= rx_en_nxt;
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      txd_r <= txd_nxt;
      tx_pend_r <= tx_pend_nxt;
      tx_done_r <= tx_done_nxt;
      rx_st_r <= rx_st_nxt;
      rx_sh_r <= rx_sh_nxt;
      rxb_r <= rxb_nxt;
      rx_half_r <= rx_half_nxt;
      rx_full_r <= rx_full_nxt;
      ovr_r <= ovr_nxt;
      frm_r <= frm_nxt;
      rx_done_r <= rx_done_nxt;
    end
  end

  assign o_txd = txd_r;
  assign o_tx_done = tx_done_r;
  assign o_rx_done = rx_done_r;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
  logic do_wr, do_rd;

  assign o_awready = !aw_r && !bv_r;
  assign o_wready = !w_r && !bv_r;
  assign o_arready = !rv_r;
  assign do_wr = aw_r && w_r && !bv_r;
  assign do_rd = i_arvalid && !rv_r;
  assign txs_wr = do_wr && (awa_r == `ASPC_OFS_TXS) && tx_en_r;
  assign txs_data = wd_r[7:0];
  assign rxb_rd = do_rd && (i_araddr == `ASPC_OFS_RXB);
  assign err_rd = do_rd && (i_araddr == `ASPC_OFS_ERR);

  logic [3:0] ws_r, ws_nxt;

  always_comb begin
    aw_nxt = aw_r;
    awa_nxt = awa_r;
    w_nxt = w_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bv_nxt = bv_r && !i_bready;
    br_nxt = br_r;
    mode_nxt = mode_r;
    baud_nxt = baud_r;
    if (i_awvalid && o_awready) begin
      aw_nxt = 1'b1;
      awa_nxt = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_nxt = 1'b1;
      wd_nxt = i_wdata;
      ws_nxt = i_wstrb;
    end
    if (do_wr) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = `ASPC_AXI_OKAY;
      unique case (awa_r)
        `ASPC_OFS_MODE: if (ws_r[0]) mode_nxt = wd_r[7:0];
        // Divisor is only taken while both directions are off
        `ASPC_OFS_BAUD: if (ws_r[0] && !mode_r.txe && !mode_r.rxe) baud_nxt = wd_r[7:0];
        `ASPC_OFS_TXS: ;
        default: br_nxt = `ASPC_AXI_DECERR;
      endcase
    end
  end

  always_comb begin
    rv_nxt = rv_r && !i_rready;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (do_rd) begin
      rv_nxt = 1'b1;
      rr_nxt = `ASPC_AXI_OKAY;
      rd_nxt = 32'h0000_0000;
      unique case (i_araddr)
        `ASPC_OFS_MODE: rd_nxt[7:0] = mode_r;
        `ASPC_OFS_BAUD: rd_nxt[7:0] = baud_r;
        `ASPC_OFS_TXS: rd_nxt[7:0] = tx_sh_r;
        `ASPC_OFS_RXB: rd_nxt[7:0] = rxb_r;
        `ASPC_OFS_ERR: begin
          rd_nxt[`ASPC_BIT_OVR] = ovr_r;
          rd_nxt[`ASPC_BIT_FRM] = frm_r;
        end
        `ASPC_OFS_STAT: begin
          rd_nxt[`ASPC_BIT_TXBUSY] = tx_pend_r || (tx_st_r != aspc_pkg::ASPC_IDLE);
          rd_nxt[`ASPC_BIT_RXFULL] = rx_full_r;
        end
        default: rr_nxt = `ASPC_AXI_DECERR;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_r <= 1'b0;
      awa_r <= 8'h00;
      w_r <= 1'b0;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      bv_r <= 1'b0;
      br_r <= `ASPC_AXI_OKAY;
      rv_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      rr_r <= `ASPC_AXI_OKAY;
      mode_r <= `ASPC_RST_MODE;
      baud_r <= `ASPC_RST_BAUD;
    end else begin
      aw_r <= aw_nxt;
      awa_r <= awa_nxt;
      w_r <= w_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      bv_r <= bv_nxt;
      br_r <= br_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rr_r <= rr_nxt;
      mode_r <= mode_nxt;
      baud_r <= baud_nxt;
    end
  end

  assign o_bvalid = bv_r;
  assign o_bresp = br_r;
  assign o_rvalid = rv_r;
  assign o_rdata = rd_r;
  assign o_rresp = rr_r;

endmodule : aspc_serial_port

// >>> design/_unused.sv
`timescale 1ns/100ps

// >>> bench/aspc_properties.sv
// Checker of the serial port's pin timing and register-bus handshakes
`timescale 1ns/100ps
module aspc_properties (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic o_txd,
  input wire logic o_tx_done,
  input wire logic o_rx_done,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  a_done_in_stop: assert property (o_tx_done |-> o_txd && $past(o_txd))
    else $error("tx done outside stop bit");
  a_tx_done_gap: assert property (o_tx_done |=> !o_tx_done [*8])
    else $error("tx done repeats within a frame");
  a_start_two: assert property ($fell(o_txd) |-> !o_txd [*2])
    else $error("start bit shorter than two cycles");
  a_rx_done_gap: assert property (o_rx_done |=> !o_rx_done [*8])
    else $error("rx done repeats within a frame");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |-> ##[1:2] o_bvalid) else $error("write response late");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read response late");
  a_ar_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read address taken while answer pending");
  a_b_once: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response not cleared");
  c_tx: cover property (o_tx_done);
  c_rx: cover property (o_rx_done);
  c_start: cover property ($fell(o_txd));
endmodule : aspc_properties

bind aspc_serial_port aspc_properties u_aspc_properties (
  .i_core_clk, .i_reset_n, .o_txd, .o_tx_done, .o_rx_done, .i_awvalid, .o_awready,
  .i_wvalid, .o_wready, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid
);

// >>> bench/aspc_line_partner.sv
// Line-side model: frame sender on the receive pin, frame catcher on the transmit pin
`timescale 1ns/100ps
module aspc_line_partner (
  input wire logic i_core_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  int bit_cyc = 4;
  int got_cnt = 0;
  logic [7:0] got_byte = 8'h00;
  initial o_rxd = 1'b1;
  task automatic level(input logic v, input int n);
    @(posedge i_core_clk);
    o_rxd <= v;
    repeat (n - 1) @(posedge i_core_clk);
  endtask : level
  // One frame, LSB first; a low stop bit is followed by an idle bit
  task automatic send(input logic [7:0] b, input logic stop);
    level(1'b0, bit_cyc);
    for (int i = 0; i < 8; i++) level(b[i], bit_cyc);
    level(stop, bit_cyc);
    if (!stop) level(1'b1, bit_cyc);
  endtask : send
  // Samples mid-bit; counts only frames with a high stop bit
  always begin
    @(negedge i_txd);
    repeat (bit_cyc / 2) @(negedge i_core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(negedge i_core_clk);
      got_byte[i] = i_txd;
    end
    repeat (bit_cyc) @(negedge i_core_clk);
    if (i_txd === 1'b1) got_cnt++;
  end
endmodule : aspc_line_partner

// >>> bench/tb_aspc_serial_port.sv
// Self-checking bench of the serial port
`timescale 1ns/100ps
`include "aspc_consts.svh"
module tb_aspc_serial_port;
  logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_internal_ring_oscillator_sel = 1'b0, i_internal_ring_oscillator_clk = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'h0;
  logic i_rxd, o_txd, o_tx_done, o_rx_done, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  int n_fail = 0, compares = 0;

  always #12.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) i_internal_ring_oscillator_clk <= ~i_internal_ring_oscillator_clk;

  aspc_serial_port u_aspc_serial_port (
    .i_core_clk, .i_reset_n, .i_internal_ring_oscillator_sel, .i_internal_ring_oscillator_clk, .i_rxd, .o_txd, .o_tx_done,
    .o_rx_done, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready
  );
  aspc_line_partner u_partner (.i_core_clk, .i_txd(o_txd), .o_rxd(i_rxd));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic aw_t, w_t, b_t;
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= 4'hF;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(negedge i_core_clk);
      aw_t = i_awvalid && o_awready;
      w_t = i_wvalid && o_wready;
      b_t = o_bvalid;
      if (b_t) check("bresp", {30'h0, o_bresp}, {30'h0, er});
      @(posedge i_core_clk);
      if (aw_t) i_awvalid <= 1'b0;
      if (w_t) i_wvalid <= 1'b0;
    end while (!b_t);
    i_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    logic ar_t, r_t;
    @(posedge i_core_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(negedge i_core_clk);
      ar_t = i_arvalid && o_arready;
      r_t = o_rvalid;
      if (r_t) check("rresp", {30'h0, o_rresp}, {30'h0, er});
      if (r_t) check("rdata", o_rdata, ed);
      @(posedge i_core_clk);
      if (ar_t) i_arvalid <= 1'b0;
    end while (!r_t);
    i_rready <= 1'b0;
  endtask : rd

  task automatic wait_done(input logic rx, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (400) begin
      @(negedge i_core_clk);
      if ((rx ? o_rx_done : o_tx_done) === 1'b1) seen = 1'b1;
      if (seen) break;
    end
    check(rx ? "rx done" : "tx done", {31'h0, seen}, {31'h0, exp});
  endtask : wait_done

  task automatic t_regs();
    rd(`ASPC_OFS_MODE, 32'h0);
    rd(`ASPC_OFS_BAUD, 32'h1F);
    rd(8'h18, 32'h0, `ASPC_AXI_DECERR);
    wr(8'h1C, 32'hFF, `ASPC_AXI_DECERR);
    wr(`ASPC_OFS_BAUD, 32'h2);
    wr(`ASPC_OFS_MODE, 32'h80);
    wr(`ASPC_OFS_MODE, 32'hE0);
    wr(`ASPC_OFS_BAUD, 32'h5);
    rd(`ASPC_OFS_BAUD, 32'h2);
  endtask : t_regs

  task automatic t_tx(input logic [7:0] b);
    int cnt;
    cnt = u_partner.got_cnt;
    wr(`ASPC_OFS_TXS, {24'h0, b});
    wait_done(1'b0, 1'b1);
    check("line byte", {24'h0, u_partner.got_byte}, {24'h0, b});
    check("line frames", u_partner.got_cnt, cnt + 1);
  endtask : t_tx

  // Second frame starts right after a single stop bit
  task automatic t_rx_pair();
    fork
      begin
        u_partner.send(8'h5A, 1'b1);
        u_partner.send(8'hC3, 1'b1);
      end
      begin
        wait_done(1'b1, 1'b1);
        rd(`ASPC_OFS_ERR, 32'h0);
        rd(`ASPC_OFS_RXB, 32'h5A);
        wait_done(1'b1, 1'b1);
        rd(`ASPC_OFS_ERR, 32'h0);
        rd(`ASPC_OFS_RXB, 32'hC3);
      end
    join
  endtask : t_rx_pair

  task automatic t_errors();
    u_partner.send(8'h11, 1'b1);
    u_partner.send(8'h22, 1'b1);
    repeat (8) @(posedge i_core_clk);
    rd(`ASPC_OFS_ERR, 32'h1);
    rd(`ASPC_OFS_RXB, 32'h11);
    rd(`ASPC_OFS_ERR, 32'h0);
    u_partner.send(8'h33, 1'b0);
    rd(`ASPC_OFS_ERR, 32'h2);
    rd(`ASPC_OFS_RXB, 32'h33);
  endtask : t_errors

  // Line already low when reception is switched on
  task automatic t_start_low();
    wr(`ASPC_OFS_MODE, 32'hC0);
    u_partner.level(1'b0, 8);
    wr(`ASPC_OFS_MODE, 32'hE0);
    u_partner.level(1'b1, 1);
    wait_done(1'b1, 1'b1);
    rd(`ASPC_OFS_ERR, 32'h0);
    rd(`ASPC_OFS_RXB, 32'hFF);
  endtask : t_start_low

  task automatic t_ring_stop();
    wr(`ASPC_OFS_MODE, 32'h80);
    i_internal_ring_oscillator_sel <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    wr(`ASPC_OFS_MODE, 32'hE0);
    repeat (8) @(posedge i_core_clk);
    u_partner.bit_cyc = 8;
    t_tx(8'h96);
    wr(`ASPC_OFS_MODE, 32'h80);
    wr(`ASPC_OFS_MODE, 32'h00);
    wr(`ASPC_OFS_TXS, 32'h55);
    wait_done(1'b0, 1'b0);
  endtask : t_ring_stop

  initial begin
    repeat (4) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    t_regs();
    t_tx(8'hA5);
    t_tx(8'h3C);
    t_rx_pair();
    t_errors();
    t_start_low();
    t_ring_stop();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_fail++;
    finish_test();
  end
endmodule : tb_aspc_serial_port
